/* File: common/fppio_params.svh */
/*
 * Register offsets, port widths and reset values for the five-port
 * parallel I/O block. Assumes inclusion by its bare name.
 */
`ifndef FPPIO_PARAMS_SVH
`define FPPIO_PARAMS_SVH

`define FPPIO_ADDR_W        4
`define FPPIO_OFF_A_LATCH   4'h0
`define FPPIO_OFF_B_LATCH   4'h1
`define FPPIO_OFF_C_LATCH   4'h2
`define FPPIO_OFF_D_LATCH   4'h3
`define FPPIO_OFF_A_DIR     4'h4
`define FPPIO_OFF_B_DIR     4'h5
`define FPPIO_OFF_C_DIR     4'h6
`define FPPIO_OFF_D_DIR     4'h7
`define FPPIO_OFF_E_LATCH   4'h8
`define FPPIO_OFF_E_DIR     4'hC
`define FPPIO_OFF_A_PULL    4'hD
`define FPPIO_OFF_C_PULL    4'hE
`define FPPIO_OFF_D_PULL    4'hF

`define FPPIO_A_WIDTH       8
`define FPPIO_B_WIDTH       8
`define FPPIO_C_WIDTH       7
`define FPPIO_D_WIDTH       8
`define FPPIO_E_WIDTH       6

`define FPPIO_DIR_RESET     8'h00
`define FPPIO_PULL_RESET    8'h00
`define FPPIO_READ_IDLE     8'h00

`endif

/* File: common/fppio_pkg.sv */
/*
 * Shared types of the five-port parallel I/O block.
 * Assumes nothing of its surroundings.
 */
package fppio_pkg;
	typedef logic [7:0] fppio_byte_t;
	typedef logic [3:0] fppio_addr_t;
endpackage

/* File: hdl/fppio_port.sv */
/*
 * One parallel port: data latch, direction register, optional pullup
 * enable register, pin drive and read-back mux.
 * Assumes pin inputs synchronous to clk_i and one-cycle write strobes.
 */
`timescale 1ns/1ps
`include "fppio_params.svh"

module fppio_port #(
	parameter int WIDTH    = 8,
	parameter bit HAS_PULL = 1'b1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             wr_latch_i,
	input  wire logic             wr_dir_i,
	input  wire logic             wr_pull_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe_o,
	output logic      [WIDTH-1:0] pull_on_o,
	output logic      [7:0]       data_rd_o,
	output logic      [7:0]       dir_rd_o,
	output logic      [7:0]       pull_rd_o
);

	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] dir_reg;
	logic [WIDTH-1:0] pull_reg;
	logic [WIDTH-1:0] data_view;

	// ********************************************
	// Storage
	// ********************************************
	// No reset: contents survive a reset, unknown until first write
	always_ff @(posedge clk_i)
	begin
		if (wr_latch_i)
		begin
			latch_reg <= wdata_i[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dir_reg <= WIDTH'(`FPPIO_DIR_RESET);
		end
		else if (wr_dir_i)
		begin
			dir_reg <= wdata_i[WIDTH-1:0];
		end
	end

	generate
		if (HAS_PULL)
		begin : g_pull
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					pull_reg <= WIDTH'(`FPPIO_PULL_RESET);
				end
				else if (wr_pull_i)
				begin
					pull_reg <= wdata_i[WIDTH-1:0];
				end
			end
		end
		else
		begin : g_nopull
			assign pull_reg = '0;
		end
	endgenerate

	// ********************************************
	// Pins and read-back
	// ********************************************
	assign pin_o     = latch_reg;
	assign pin_oe_o  = dir_reg;
	assign pull_on_o = pull_reg & ~dir_reg;
	assign data_view = (dir_reg & latch_reg) | (~dir_reg & pin_i);

	always_comb
	begin
		data_rd_o = `FPPIO_READ_IDLE;
		dir_rd_o  = `FPPIO_READ_IDLE;
		pull_rd_o = `FPPIO_READ_IDLE;
		data_rd_o[WIDTH-1:0] = data_view;
		dir_rd_o[WIDTH-1:0]  = dir_reg;
		pull_rd_o[WIDTH-1:0] = pull_reg;
	end

endmodule

/* File: hdl/fppio_top.sv */
/*
 * Five-port parallel I/O block: register decode and read data for ports
 * A to E. Assumes a simple strobe register port, read data one cycle
 * after the read strobe, and pins synchronous to clk_i.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "fppio_params.svh"

module fppio_top #(
	parameter int A_W = `FPPIO_A_WIDTH,
	parameter int B_W = `FPPIO_B_WIDTH,
	parameter int C_W = `FPPIO_C_WIDTH,
	parameter int D_W = `FPPIO_D_WIDTH,
	parameter int E_W = `FPPIO_E_WIDTH
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire fppio_pkg::fppio_addr_t addr_i,
	input  wire fppio_pkg::fppio_byte_t wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output fppio_pkg::fppio_byte_t     rdata_o,
	input  wire logic [A_W-1:0]        port_a_pin_i,
	output logic      [A_W-1:0]        port_a_pin_o,
	output logic      [A_W-1:0]        port_a_oe_o,
	output logic      [A_W-1:0]        port_a_pull_o,
	input  wire logic [B_W-1:0]        port_b_pin_i,
	output logic      [B_W-1:0]        port_b_pin_o,
	output logic      [B_W-1:0]        port_b_oe_o,
	input  wire logic [C_W-1:0]        port_c_pin_i,
	output logic      [C_W-1:0]        port_c_pin_o,
	output logic      [C_W-1:0]        port_c_oe_o,
	output logic      [C_W-1:0]        port_c_pull_o,
	input  wire logic [D_W-1:0]        port_d_pin_i,
	output logic      [D_W-1:0]        port_d_pin_o,
	output logic      [D_W-1:0]        port_d_oe_o,
	output logic      [D_W-1:0]        port_d_pull_o,
	input  wire logic [E_W-1:0]        port_e_pin_i,
	output logic      [E_W-1:0]        port_e_pin_o,
	output logic      [E_W-1:0]        port_e_oe_o
);

	// ********************************************
	// Write decode
	// ********************************************
	function automatic logic hit(input fppio_pkg::fppio_addr_t a,
		input fppio_pkg::fppio_addr_t off);
		hit = (a == off);
	endfunction

	fppio_pkg::fppio_byte_t a_dat, a_dir, a_pul;
	fppio_pkg::fppio_byte_t b_dat, b_dir;
	fppio_pkg::fppio_byte_t c_dat, c_dir, c_pul;
	fppio_pkg::fppio_byte_t d_dat, d_dir, d_pul;
	fppio_pkg::fppio_byte_t e_dat, e_dir;
	fppio_pkg::fppio_byte_t rdata_reg;
	fppio_pkg::fppio_byte_t rdata_next;

	// ********************************************
	// Ports
	// ********************************************
	fppio_port #(.WIDTH(A_W), .HAS_PULL(1'b1)) u_port_a (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.wr_latch_i (wr_i && hit(addr_i, `FPPIO_OFF_A_LATCH)),
		.wr_dir_i   (wr_i && hit(addr_i, `FPPIO_OFF_A_DIR)),
		.wr_pull_i  (wr_i && hit(addr_i, `FPPIO_OFF_A_PULL)),
		.wdata_i    (wdata_i),
		.pin_i      (port_a_pin_i),
		.pin_o      (port_a_pin_o),
		.pin_oe_o   (port_a_oe_o),
		.pull_on_o  (port_a_pull_o),
		.data_rd_o  (a_dat),
		.dir_rd_o   (a_dir),
		.pull_rd_o  (a_pul)
	);

	fppio_port #(.WIDTH(B_W), .HAS_PULL(1'b0)) u_port_b (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.wr_latch_i (wr_i && hit(addr_i, `FPPIO_OFF_B_LATCH)),
		.wr_dir_i   (wr_i && hit(addr_i, `FPPIO_OFF_B_DIR)),
		.wr_pull_i  (1'b0),
		.wdata_i    (wdata_i),
		.pin_i      (port_b_pin_i),
		.pin_o      (port_b_pin_o),
		.pin_oe_o   (port_b_oe_o),
		.pull_on_o  (),
		.data_rd_o  (b_dat),
		.dir_rd_o   (b_dir),
		.pull_rd_o  ()
	);

	fppio_port #(.WIDTH(C_W), .HAS_PULL(1'b1)) u_port_c (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.wr_latch_i (wr_i && hit(addr_i, `FPPIO_OFF_C_LATCH)),
		.wr_dir_i   (wr_i && hit(addr_i, `FPPIO_OFF_C_DIR)),
		.wr_pull_i  (wr_i && hit(addr_i, `FPPIO_OFF_C_PULL)),
		.wdata_i    (wdata_i),
		.pin_i      (port_c_pin_i),
		.pin_o      (port_c_pin_o),
		.pin_oe_o   (port_c_oe_o),
		.pull_on_o  (port_c_pull_o),
		.data_rd_o  (c_dat),
		.dir_rd_o   (c_dir),
		.pull_rd_o  (c_pul)
	);

	fppio_port #(.WIDTH(D_W), .HAS_PULL(1'b1)) u_port_d (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.wr_latch_i (wr_i && hit(addr_i, `FPPIO_OFF_D_LATCH)),
		.wr_dir_i   (wr_i && hit(addr_i, `FPPIO_OFF_D_DIR)),
		.wr_pull_i  (wr_i && hit(addr_i, `FPPIO_OFF_D_PULL)),
		.wdata_i    (wdata_i),
		.pin_i      (port_d_pin_i),
		.pin_o      (port_d_pin_o),
		.pin_oe_o   (port_d_oe_o),
		.pull_on_o  (port_d_pull_o),
		.data_rd_o  (d_dat),
		.dir_rd_o   (d_dir),
		.pull_rd_o  (d_pul)
	);

	fppio_port #(.WIDTH(E_W), .HAS_PULL(1'b0)) u_port_e (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.wr_latch_i (wr_i && hit(addr_i, `FPPIO_OFF_E_LATCH)),
		.wr_dir_i   (wr_i && hit(addr_i, `FPPIO_OFF_E_DIR)),
		.wr_pull_i  (1'b0),
		.wdata_i    (wdata_i),
		.pin_i      (port_e_pin_i),
		.pin_o      (port_e_pin_o),
		.pin_oe_o   (port_e_oe_o),
		.pull_on_o  (),
		.data_rd_o  (e_dat),
		.dir_rd_o   (e_dir),
		.pull_rd_o  ()
	);

	// ********************************************
	// Read path
	// ********************************************
	// Unmapped offsets 9 to B read zero; pin is sampled in the read cycle.
	always_comb
	begin
		rdata_next = `FPPIO_READ_IDLE;
		unique case (addr_i)
			`FPPIO_OFF_A_LATCH: rdata_next = a_dat;
			`FPPIO_OFF_B_LATCH: rdata_next = b_dat;
			`FPPIO_OFF_C_LATCH: rdata_next = c_dat;
			`FPPIO_OFF_D_LATCH: rdata_next = d_dat;
			`FPPIO_OFF_A_DIR:   rdata_next = a_dir;
			`FPPIO_OFF_B_DIR:   rdata_next = b_dir;
			`FPPIO_OFF_C_DIR:   rdata_next = c_dir;
			`FPPIO_OFF_D_DIR:   rdata_next = d_dir;
			`FPPIO_OFF_E_LATCH: rdata_next = e_dat;
			`FPPIO_OFF_E_DIR:   rdata_next = e_dir;
			`FPPIO_OFF_A_PULL:  rdata_next = a_pul;
			`FPPIO_OFF_C_PULL:  rdata_next = c_pul;
			`FPPIO_OFF_D_PULL:  rdata_next = d_pul;
			default:            rdata_next = `FPPIO_READ_IDLE;
		endcase
	end

	// Data stands only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_reg <= `FPPIO_READ_IDLE;
		end
		else
		begin
			rdata_reg <= rd_i ? rdata_next : `FPPIO_READ_IDLE;
		end
	end

	assign rdata_o = rdata_reg;

endmodule

/* File: verification/fppio_chk.sv */
/*
 * Port-level assertions for fppio_top.
 * Assumes binding into fppio_top, one clock, async low reset.
 */
`timescale 1ns/1ps
module fppio_chk #(
	parameter int A_W = 8, B_W = 8, C_W = 7, D_W = 8, E_W = 6
) (
	input wire logic                   clk_i,
	input wire logic                   rst_n_i,
	input wire fppio_pkg::fppio_addr_t addr_i,
	input wire fppio_pkg::fppio_byte_t wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire fppio_pkg::fppio_byte_t rdata_o,
	input wire logic [A_W-1:0]         port_a_pin_i,
	input wire logic [A_W-1:0]         port_a_pin_o,
	input wire logic [A_W-1:0]         port_a_oe_o,
	input wire logic [A_W-1:0]         port_a_pull_o,
	input wire logic [B_W-1:0]         port_b_pin_o,
	input wire logic [C_W-1:0]         port_c_oe_o,
	input wire logic [C_W-1:0]         port_c_pull_o,
	input wire logic [D_W-1:0]         port_d_oe_o,
	input wire logic [D_W-1:0]         port_d_pull_o,
	input wire logic [E_W-1:0]         port_e_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ****
	// Port relations
	// ****
	property p_pull_off; (port_a_pull_o & port_a_oe_o) == 0 &&
		(port_d_pull_o & port_d_oe_o) == 0; endproperty
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	property p_dir_a; wr_i && addr_i == 4'h4 |=>
		port_a_oe_o == $past(wdata_i); endproperty
	property p_latch_b; wr_i && addr_i == 4'h1 |=>
		port_b_pin_o == $past(wdata_i); endproperty
	// Pull follows the write only where the pin is not driven
	property p_pull_c; wr_i && addr_i == 4'hE |=>
		port_c_pull_o == ($past(wdata_i) & {1'b0, ~port_c_oe_o}); endproperty
	property p_dir_c; rd_i && addr_i == 4'h6 |=>
		rdata_o == {1'b0, port_c_oe_o}; endproperty
	property p_dir_e; rd_i && addr_i == 4'hC |=>
		rdata_o == {2'b00, port_e_oe_o}; endproperty
	property p_latch_e; rd_i && addr_i == 4'h8 |=> rdata_o[7:6] == 2'b00; endproperty
	property p_unmapped; rd_i && addr_i inside {4'h9, 4'hA, 4'hB} |=>
		rdata_o == 8'h00; endproperty
	property p_read_a; rd_i && addr_i == 4'h0 |=> rdata_o ==
		(($past(port_a_oe_o) & $past(port_a_pin_o)) |
		(~$past(port_a_oe_o) & $past(port_a_pin_i))); endproperty
	property p_d_hold; !wr_i |=> $stable(port_d_oe_o); endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull on output");
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	a_dir_a: assert property (p_dir_a) else $error("port a enable");
	a_latch_b: assert property (p_latch_b) else $error("port b latch");
	a_pull_c: assert property (p_pull_c) else $error("port c pull");
	a_dir_c: assert property (p_dir_c) else $error("port c dir read");
	a_dir_e: assert property (p_dir_e) else $error("port e dir read");
	a_latch_e: assert property (p_latch_e) else $error("port e top bits");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_read_a: assert property (p_read_a) else $error("port a data read");
	a_d_hold: assert property (p_d_hold) else $error("port d dir moved");
	c_pull_wr: cover property (wr_i && addr_i == 4'hE);
	c_read_a: cover property (rd_i && addr_i == 4'h0);
	c_unmapped: cover property (rd_i && addr_i == 4'h9);
endmodule
bind fppio_top fppio_chk #(.A_W(A_W), .B_W(B_W), .C_W(C_W), .D_W(D_W),
	.E_W(E_W)) u_chk (.*);

/* File: verification/fppio_pins.sv */
/*
 * Pad model for all five ports, bits packed A to E.
 * Assumes the bench supplies the far-side level of undriven pins.
 */
`timescale 1ns/1ps
module fppio_pins #(
	parameter int W = 37
) (
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] drv_i,
	input  wire logic [W-1:0] pull_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pin_o
);
	// ****
	// Pad level
	// ****
	// Own driver wins, then pullup, else far side; no float modelled
	assign pin_o = (oe_i & drv_i) | (~oe_i & (pull_i | ext_i));
endmodule

/* File: verification/tb.sv */
/*
 * Self-checking bench for fppio_top through its register port.
 * Assumes fppio_pins and the design files compile first.
 */
`timescale 1ns/1ps
module tb;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   wr = 1'b0;
	logic                   rd = 1'b0;
	fppio_pkg::fppio_addr_t addr = 4'h0;
	fppio_pkg::fppio_byte_t wdata = 8'h00;
	fppio_pkg::fppio_byte_t rdata;
	logic [36:0]            ext = 37'h0;
	wire  [36:0]            pi, po, oe, pu;
	wire  [7:0]             pa, pd;
	wire  [6:0]             pc;
	int                     n_mismatch = 0, n_checks = 0, cyc = 0;
	fppio_pkg::fppio_byte_t mask [16] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF,
		8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'h7F, 8'hFF};
	// ****
	// Harness
	// ****
	assign pu = {pa, 8'h00, pc, pd, 6'h00};
	always #4 clk = ~clk;
	fppio_top uut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .port_a_pin_i(pi[36:29]),
		.port_a_pin_o(po[36:29]), .port_a_oe_o(oe[36:29]), .port_a_pull_o(pa),
		.port_b_pin_i(pi[28:21]), .port_b_pin_o(po[28:21]), .port_b_oe_o(oe[28:21]),
		.port_c_pin_i(pi[20:14]), .port_c_pin_o(po[20:14]), .port_c_oe_o(oe[20:14]),
		.port_c_pull_o(pc), .port_d_pin_i(pi[13:6]), .port_d_pin_o(po[13:6]),
		.port_d_oe_o(oe[13:6]), .port_d_pull_o(pd), .port_e_pin_i(pi[5:0]),
		.port_e_pin_o(po[5:0]), .port_e_oe_o(oe[5:0]));
	fppio_pins #(.W(37)) pads (.oe_i(oe), .drv_i(po), .pull_i(pu), .ext_i(ext),
		.pin_o(pi));
	task automatic check(input logic [36:0] seen, input logic [36:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// Read data stand for one cycle only, so sample right after that edge
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask
	task automatic give_verdict;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	// ****
	// Tests
	// ****
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 4; i < 16; i++)
			rd_reg(i[3:0], 8'h00);
		check(oe, 37'h0);
		for (int i = 0; i < 16; i++)
			wr_reg(i[3:0], 8'hFF);
		for (int i = 0; i < 16; i++)
			rd_reg(i[3:0], mask[i]);
		check(pu, 37'h0);
		check(oe, {37{1'b1}});
		check(po, {37{1'b1}});
		@(posedge clk);
		ext <= {8'h00, 8'hA5, 7'h2A, 8'h00, 6'h15};
		wr_reg(4'h4, 8'h0F);
		check(pa, 8'hF0);
		wr_reg(4'hD, 8'h30);
		rd_reg(4'h0, 8'h3F);
		wr_reg(4'h0, 8'h05);
		rd_reg(4'h0, 8'h35);
		wr_reg(4'h4, 8'hFF);
		check(pa, 8'h00);
		rd_reg(4'h0, 8'h05);
		wr_reg(4'h4, 8'h00);
		check(pa, 8'h30);
		wr_reg(4'h7, 8'h00);
		check(pd, 8'hFF);
		wr_reg(4'h5, 8'h00);
		rd_reg(4'h1, 8'hA5);
		wr_reg(4'h6, 8'h00);
		wr_reg(4'hE, 8'h00);
		rd_reg(4'h2, 8'h2A);
		wr_reg(4'hC, 8'h00);
		rd_reg(4'h8, 8'h15);
		wr_reg(4'h5, 8'hFF);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		check(oe, 37'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		wr_reg(4'h5, 8'hFF);
		wr_reg(4'h4, 8'hFF);
		rd_reg(4'h1, 8'hFF);
		rd_reg(4'h0, 8'h05);
		give_verdict;
	end
endmodule
